// ===== src/lbhs_dev.sv
// Bridge end of the local bus: arbitration, selects, parity, DMA request, straps.
// Assumes local bus signals are synchronous to mclk; the processor end keeps its side.
// Functional notes
// (R01) Bus request changes only on rising edge
// (R02) Strap high at reset sets master enable
// (R03) FIFO-ready function unused in this mode
// (R04) Initiator drives burst indicator for bursts
// (R05) PCI select accepted up to three clocks late
// (R06) DMA: PCI select means single-address transfer
// (R07) Register select accepted up to three clocks
// (R08) Parity valid with the data it covers
// (R09) DMA acknowledge marks a DMA transaction
// (R10) DMA done input is ignored
// (R11) DMA request fills or empties inbound FIFO
// (R12) DMA request changes on rising edge
// (R13) Reset-sampled burst pin selects master protocol
// (R14) Register offset from low 12 address bits
// (R15) Address sampled on transfer start edge
// (R16) One parity bit per byte lane
`timescale 1ns/1ps
`include "lbhs_map.svh"
module lbhs_dev #(
   parameter int DEPTH = `LBHS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Local bus
   lbhs_if.dev lb,
   // User side: master request and status
   input wire logic want_master,
   input wire logic pci_write_dir,
   output logic master_enable,
   output logic protocol_new,
   output logic bus_owned,
   // User side: decoded slave access
   output logic acc_valid,
   output logic acc_is_reg,
   output logic acc_single_addr,
   output logic acc_dma,
   output logic acc_write,
   output logic [`LBHS_REG_ADDR_W-1:0] acc_reg_offset,
   output logic parity_error,
   // User side: inbound FIFO drain
   output logic ififo_valid,
   input wire logic ififo_ready,
   output logic [`LBHS_DATA_W-1:0] ififo_data
);
   lbhs_pkg::lbhs_slv_state_t st_q, st_d;
   logic reset_seen_q, strap_done_q;
   logic master_enable_q, protocol_new_q;
   logic bus_request_n_q, busy_oe_q, bus_owned_q;
   logic dma_request_n_q;
   logic [`LBHS_SEL_CNT_W-1:0] wait_q;
   logic [`LBHS_DATA_W-1:0] addr_q;
   logic write_q, dma_q;
   logic acc_valid_q, acc_is_reg_q, acc_single_q, acc_dma_q, acc_write_q, perr_q;
   logic [`LBHS_REG_ADDR_W-1:0] acc_off_q;
   logic [`LBHS_PAR_W-1:0] rpar_q;
   logic fifo_in_ready;
   logic [`LBHS_PAR_W-1:0] wpar_calc;

   genvar gb;
   for (gb = 0; gb < `LBHS_PAR_W; gb++) begin : g_par
      assign wpar_calc[gb] = ^lb.wdata[gb*8 +: 8] ^ `LBHS_ODD_PARITY; // R16
   end

   wire ts = !lb.transfer_start_n;
   wire sel_pci = !lb.pci_window_select_n;
   wire sel_reg = !lb.register_select_n;
   wire sel_any = sel_pci || sel_reg;
   wire dma_now = !lb.dma_ack_n; // R09
   // Last wait state: a select later than three clocks after start is refused
   wire win_exp = (wait_q == `LBHS_SEL_CNT_W'(`LBHS_SEL_WAIT_MAX - 1));
   wire in_idle = (st_q == lbhs_pkg::LBHS_S_IDLE);
   // A select on the start clock is taken at once, so its qualifiers are read live
   wire take = ((in_idle && ts) || st_q == lbhs_pkg::LBHS_S_WAIT) && sel_any; // R05 R07
   wire cur_write = in_idle ? !lb.transfer_rw : write_q;
   wire cur_dma = in_idle ? dma_now : dma_q;
   wire [`LBHS_REG_ADDR_W-1:0] cur_off = in_idle ? lb.addr[`LBHS_REG_ADDR_W-1:0] :
                                        addr_q[`LBHS_REG_ADDR_W-1:0];
   wire par_bad = cur_write && (lb.wpar != wpar_calc); // R08
   wire fifo_push = take && sel_pci && cur_write && cur_dma;
   wire fifo_ok = fifo_in_ready;
   // DMA request reflects FIFO room for PCI writes; DONE has no say here
   wire dma_request_n_d = !(pci_write_dir ? fifo_ok : ififo_valid); // R11 R10

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         lbhs_pkg::LBHS_S_IDLE: begin
            if (ts) st_d = sel_any ? lbhs_pkg::LBHS_S_ACC : lbhs_pkg::LBHS_S_WAIT;
         end
         lbhs_pkg::LBHS_S_WAIT: begin
            if (sel_any) st_d = lbhs_pkg::LBHS_S_ACC;
            else if (win_exp) st_d = lbhs_pkg::LBHS_S_IDLE;
         end
         lbhs_pkg::LBHS_S_ACC: st_d = lbhs_pkg::LBHS_S_IDLE;
         default: st_d = lbhs_pkg::LBHS_S_IDLE;
      endcase
   end

   // Strap capture happens on the first clock after release, never in the reset branch
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reset_seen_q <= 1'b0;
         strap_done_q <= 1'b0;
         master_enable_q <= 1'b0;
         protocol_new_q <= 1'b0;
      end else begin
         reset_seen_q <= 1'b1;
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            master_enable_q <= lb.master_enable_strap; // R02 R03
            protocol_new_q <= lb.burst_data_in_progress_n; // R13
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bus_request_n_q <= 1'b1;
         busy_oe_q <= 1'b0;
         bus_owned_q <= 1'b0;
      end else begin
         bus_request_n_q <= !(want_master && master_enable_q && !bus_owned_q); // R01
         bus_owned_q <= want_master && (bus_owned_q ||
                        (!lb.bus_grant_n && lb.bus_busy_n && !bus_request_n_q));
         busy_oe_q <= bus_owned_q;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) dma_request_n_q <= 1'b1;
      else dma_request_n_q <= dma_request_n_d; // R12
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= lbhs_pkg::LBHS_S_IDLE;
         wait_q <= '0;
         addr_q <= '0;
         write_q <= 1'b0;
         dma_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (st_q == lbhs_pkg::LBHS_S_IDLE && ts) begin
            addr_q <= lb.addr; // R15
            write_q <= !lb.transfer_rw;
            dma_q <= dma_now;
            wait_q <= '0;
         end else if (st_q == lbhs_pkg::LBHS_S_WAIT) begin
            wait_q <= wait_q + 1'b1; // R05 R07
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_valid_q <= 1'b0;
         acc_is_reg_q <= 1'b0;
         acc_single_q <= 1'b0;
         acc_dma_q <= 1'b0;
         acc_write_q <= 1'b0;
         acc_off_q <= '0;
         perr_q <= 1'b0;
         rpar_q <= '0;
      end else begin
         acc_valid_q <= take;
         perr_q <= take && par_bad;
         rpar_q <= '0;
         if (take) begin
            acc_is_reg_q <= sel_reg && !sel_pci;
            acc_single_q <= cur_dma && sel_pci; // R06
            acc_dma_q <= cur_dma;
            acc_write_q <= cur_write;
            acc_off_q <= cur_off; // R14
         end
      end
   end

   lbhs_fifo #(.WIDTH(`LBHS_DATA_W), .DEPTH(DEPTH)) u_ififo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(lb.wdata),
      .out_valid(ififo_valid),
      .out_ready(ififo_ready),
      .out_data(ififo_data)
   );

   assign lb.bus_request_n = bus_request_n_q;
   assign lb.bus_busy_n_dev = !bus_owned_q;
   assign lb.bus_busy_oe_dev = busy_oe_q;
   assign lb.dma_request_n = dma_request_n_q;
   assign lb.rdata = '0;
   assign lb.rpar = rpar_q; // R08
   assign lb.xfer_ack_n = !acc_valid_q;
   assign master_enable = master_enable_q;
   assign protocol_new = protocol_new_q;
   assign bus_owned = bus_owned_q;
   assign acc_valid = acc_valid_q;
   assign acc_is_reg = acc_is_reg_q;
   assign acc_single_addr = acc_single_q;
   assign acc_dma = acc_dma_q;
   assign acc_write = acc_write_q;
   assign acc_reg_offset = acc_off_q;
   assign parity_error = perr_q;
endmodule

// ===== src/lbhs_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
`timescale 1ns/1ps
module lbhs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q, rptr_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rptr_q];
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
         if (pop) rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   genvar gi;
   for (gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_ff @(posedge mclk) begin
         if (push && wptr_q == AW'(gi)) mem_q[gi] <= in_data;
      end
   end
endmodule

// ===== src/lbhs_if.sv
// Local bus carrier between the bridge end and the processor end.
// Assumes one clock; two-way pins resolve here from output enables.
`timescale 1ns/1ps
`include "lbhs_map.svh"
interface lbhs_if;
   // Arbitration
   logic bus_request_n;
   logic bus_grant_n;
   logic bus_busy_n_dev;
   logic bus_busy_oe_dev;
   logic bus_busy_n;
   // Transfer control
   logic transfer_start_n;
   logic transfer_rw;
   logic burst_indicator_n;
   logic [`LBHS_DATA_W-1:0] addr;
   logic pci_window_select_n;
   logic register_select_n;
   // Data
   logic [`LBHS_DATA_W-1:0] wdata;
   logic [`LBHS_PAR_W-1:0] wpar;
   logic [`LBHS_DATA_W-1:0] rdata;
   logic [`LBHS_PAR_W-1:0] rpar;
   logic xfer_ack_n;
   // DMA and straps
   logic dma_request_n;
   logic dma_ack_n;
   logic dma_done_n;
   logic master_enable_strap;
   logic burst_data_in_progress_n;
   assign bus_busy_n = bus_busy_oe_dev ? bus_busy_n_dev : 1'b1;
   modport dev (
      output bus_request_n, bus_busy_n_dev, bus_busy_oe_dev, dma_request_n, rdata, rpar,
      xfer_ack_n,
      input bus_grant_n, bus_busy_n, transfer_start_n, transfer_rw, burst_indicator_n, addr,
      pci_window_select_n, register_select_n, wdata, wpar, dma_ack_n, dma_done_n,
      master_enable_strap, burst_data_in_progress_n
   );
   modport proc (
      input bus_request_n, bus_busy_n, dma_request_n, rdata, rpar, xfer_ack_n,
      output bus_grant_n, transfer_start_n, transfer_rw, burst_indicator_n, addr,
      pci_window_select_n, register_select_n, wdata, wpar, dma_ack_n, dma_done_n,
      master_enable_strap, burst_data_in_progress_n
   );
endinterface

// ===== src/lbhs_map.svh
// Constants for the local bus handshake ends: codes, widths and timing counts.
// Assumes both ends run on the one local bus clock.
`ifndef LBHS_MAP_SVH
`define LBHS_MAP_SVH
`define LBHS_DATA_W 32
`define LBHS_PAR_W 4
`define LBHS_REG_ADDR_W 12
`define LBHS_SEL_WAIT_MAX 3
`define LBHS_SEL_CNT_W 2
`define LBHS_FIFO_DEPTH 16
`define LBHS_ODD_PARITY 1'b0
`define LBHS_BURST_LEN 4
`endif

// ===== src/lbhs_pkg.sv
// Types for the local bus handshake; the bridge end uses the slave state type.
// Assumes the macro header is included where constants are needed.
package lbhs_pkg;
   typedef enum logic [4:0] {
      LBHS_IDLE = 5'h01,
      LBHS_REQ = 5'h02,
      LBHS_OWN = 5'h04,
      LBHS_XFER = 5'h08,
      LBHS_DONE = 5'h10
   } lbhs_mst_state_t;
   typedef enum logic [2:0] {
      LBHS_S_IDLE = 3'h1,
      LBHS_S_WAIT = 3'h2,
      LBHS_S_ACC = 3'h4
   } lbhs_slv_state_t;
endpackage

// ===== src/lbhs_proc.sv
// Processor end: arbiter grant, transfer start with delayed select, DMA acknowledge.
// Assumes the bridge end sits on the same interface and clock.
`timescale 1ns/1ps
`include "lbhs_map.svh"
module lbhs_proc (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Local bus
   lbhs_if.proc lb,
   // User side
   input wire logic start,
   input wire logic start_write,
   input wire logic start_burst,
   input wire logic start_pci,
   input wire logic [1:0] sel_delay,
   input wire logic [`LBHS_DATA_W-1:0] start_addr,
   input wire logic [`LBHS_DATA_W-1:0] start_data,
   input wire logic strap_master_en,
   input wire logic strap_new_proto,
   output logic busy,
   output logic done
);
   logic ts_n_q, sel_pci_n_q, sel_reg_n_q, burst_n_q, rw_q, dack_n_q, grant_n_q, busy_q, done_q;
   logic [1:0] dly_q;
   logic pend_q, pci_q;
   logic [`LBHS_DATA_W-1:0] addr_q, data_q;
   logic [`LBHS_PAR_W-1:0] par;
   genvar gb;
   for (gb = 0; gb < `LBHS_PAR_W; gb++) begin : g_par
      assign par[gb] = ^data_q[gb*8 +: 8] ^ `LBHS_ODD_PARITY; // R16 R08
   end
   wire dma_go = !lb.dma_request_n && !busy_q; // R09
   wire sel_now = pend_q && (dly_q == 2'h0);
   wire pci_go = start_pci || dma_go;
   // A zero delay puts the select out with transfer start itself
   wire sel_first = (sel_delay == 2'h0);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ts_n_q <= 1'b1;
         sel_pci_n_q <= 1'b1;
         sel_reg_n_q <= 1'b1;
         burst_n_q <= 1'b1;
         rw_q <= 1'b1;
         dack_n_q <= 1'b1;
         grant_n_q <= 1'b1;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         dly_q <= '0;
         pend_q <= 1'b0;
         pci_q <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
      end else begin
         grant_n_q <= lb.bus_request_n;
         ts_n_q <= 1'b1;
         done_q <= 1'b0;
         if (!busy_q && (start || dma_go)) begin
            busy_q <= 1'b1;
            pend_q <= !sel_first;
            ts_n_q <= 1'b0;
            if (sel_first) begin
               sel_pci_n_q <= !pci_go;
               sel_reg_n_q <= pci_go;
            end
            burst_n_q <= !start_burst; // R04
            rw_q <= !start_write;
            dack_n_q <= !dma_go;
            dly_q <= sel_delay - 2'h1; // R05 R07
            pci_q <= pci_go;
            addr_q <= start_addr;
            data_q <= start_data;
         end else if (sel_now) begin
            pend_q <= 1'b0;
            sel_pci_n_q <= !pci_q;
            sel_reg_n_q <= pci_q;
         end else if (pend_q) begin
            dly_q <= dly_q - 2'h1;
         end else if (busy_q && !lb.xfer_ack_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            sel_pci_n_q <= 1'b1;
            sel_reg_n_q <= 1'b1;
            burst_n_q <= 1'b1;
            dack_n_q <= 1'b1;
         end
      end
   end
   assign lb.bus_grant_n = grant_n_q;
   assign lb.transfer_start_n = ts_n_q;
   assign lb.transfer_rw = rw_q;
   assign lb.burst_indicator_n = burst_n_q;
   assign lb.addr = addr_q;
   assign lb.pci_window_select_n = sel_pci_n_q;
   assign lb.register_select_n = sel_reg_n_q;
   assign lb.wdata = data_q;
   assign lb.wpar = par;
   assign lb.dma_ack_n = dack_n_q;
   assign lb.dma_done_n = 1'b1;
   assign lb.master_enable_strap = strap_master_en; // R02
   assign lb.burst_data_in_progress_n = strap_new_proto;
   assign busy = busy_q;
   assign done = done_q;
endmodule

// ===== tb/lbhs_properties.sv
// Concurrent checks on the local bus between the bridge end and the processor end.
// Assumes one clock and the interface signals handed in as plain inputs.
`timescale 1ns/1ps
module lbhs_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Bus signals
   input wire logic bus_request_n,
   input wire logic bus_grant_n,
   input wire logic bus_busy_n,
   input wire logic transfer_start_n,
   input wire logic pci_window_select_n,
   input wire logic register_select_n,
   input wire logic xfer_ack_n,
   input wire logic [31:0] rdata,
   input wire logic [3:0] rpar,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wpar,
   input wire logic dma_request_n,
   input wire logic master_enable_strap
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire sel_any = !pci_window_select_n || !register_select_n;
   sequence ts_seen;
      $fell(transfer_start_n);
   endsequence
   sequence sel_late;
      ##[0:3] $rose(sel_any);
   endsequence
   reset_idle_a: assert property ($rose(reset_n) |-> bus_request_n && xfer_ack_n)
      else $error("bus outputs active after reset");
   grant_after_req_a: assert property ($fell(bus_grant_n) |-> $past(!bus_request_n))
      else $error("grant without request");
   busy_after_grant_a: assert property ($fell(bus_grant_n) |-> ##[1:3] !bus_busy_n)
      else $error("bus busy not driven after grant");
   busy_needs_grant_a: assert property ($fell(bus_busy_n) |-> $past(!bus_grant_n))
      else $error("bus busy without grant");
   req_needs_strap_a: assert property (!bus_request_n |-> master_enable_strap)
      else $error("bus request with master disabled");
   ack_after_sel_a: assert property (ts_seen ##0 sel_late |-> ##1 !xfer_ack_n)
      else $error("no acknowledge one cycle after select");
   ack_one_cycle_a: assert property ($fell(xfer_ack_n) |=> xfer_ack_n)
      else $error("acknowledge longer than one cycle");
   parity_even_a: assert property (rpar == {^rdata[31:24], ^rdata[23:16],
      ^rdata[15:8], ^rdata[7:0]}) else $error("read parity wrong");
   write_parity_a: assert property (wpar == {^wdata[31:24], ^wdata[23:16],
      ^wdata[15:8], ^wdata[7:0]}) else $error("write parity wrong");
   select_window_a: assert property (ts_seen |-> sel_late)
      else $error("select outside three clocks of transfer start");
endmodule

// ===== tb/local_bus_handshake_signals_tb.sv
// Bench for both local bus ends joined by the carrier interface.
// Assumes the processor end answers DMA requests on its own.
`timescale 1ns/1ps
module local_bus_handshake_signals_tb;
   localparam int DEPTH = 4;
   logic mclk, reset_n, want_master, pci_write_dir, ififo_ready;
   logic start, start_write, start_burst, start_pci, strap_master_en, strap_new_proto;
   logic [1:0] sel_delay;
   logic [31:0] start_addr, start_data, ififo_data;
   logic [11:0] acc_reg_offset;
   logic master_enable, protocol_new, bus_owned, acc_valid, acc_is_reg, acc_single_addr;
   logic acc_dma, acc_write, parity_error, ififo_valid, busy, done;
   int failures, compares, cycles, n;
   lbhs_if lb ();
   lbhs_dev #(.DEPTH(DEPTH)) lbhs_dev_i (.mclk(mclk), .reset_n(reset_n), .lb(lb),
      .want_master(want_master), .pci_write_dir(pci_write_dir), .master_enable(master_enable),
      .protocol_new(protocol_new), .bus_owned(bus_owned), .acc_valid(acc_valid),
      .acc_is_reg(acc_is_reg), .acc_single_addr(acc_single_addr), .acc_dma(acc_dma),
      .acc_write(acc_write), .acc_reg_offset(acc_reg_offset), .parity_error(parity_error),
      .ififo_valid(ififo_valid), .ififo_ready(ififo_ready), .ififo_data(ififo_data));
   lbhs_proc lbhs_proc_i (.mclk(mclk), .reset_n(reset_n), .lb(lb), .start(start),
      .start_write(start_write), .start_burst(start_burst), .start_pci(start_pci),
      .sel_delay(sel_delay), .start_addr(start_addr), .start_data(start_data),
      .strap_master_en(strap_master_en), .strap_new_proto(strap_new_proto), .busy(busy),
      .done(done));
   lbhs_properties lbhs_properties_i (.mclk(mclk), .reset_n(reset_n),
      .bus_request_n(lb.bus_request_n), .bus_grant_n(lb.bus_grant_n),
      .bus_busy_n(lb.bus_busy_n), .transfer_start_n(lb.transfer_start_n),
      .pci_window_select_n(lb.pci_window_select_n), .register_select_n(lb.register_select_n),
      .xfer_ack_n(lb.xfer_ack_n), .rdata(lb.rdata), .rpar(lb.rpar),
      .wdata(lb.wdata), .wpar(lb.wpar),
      .dma_request_n(lb.dma_request_n), .master_enable_strap(lb.master_enable_strap));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic test_done();
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Straps only move while reset is held, as a board would wire them
   task automatic do_reset(input logic strap, input logic proto);
      reset_n = 1'b0;
      strap_master_en = strap;
      strap_new_proto = proto;
      tick(16);
      reset_n = 1'b1;
      tick(2);
      chk("master_enable", {31'h0, strap}, {31'h0, master_enable});
      chk("protocol_new", {31'h0, proto}, {31'h0, protocol_new});
   endtask
   task automatic access(input logic wr, input logic pci, input logic [1:0] d,
      input logic [31:0] addr);
      start = 1'b1;
      start_write = wr;
      start_pci = pci;
      start_burst = d[0];
      sel_delay = d;
      start_addr = addr;
      start_data = addr ^ 32'h5a5a_0f0f;
      tick(1);
      start = 1'b0;
      n = 0;
      while (acc_valid !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("acc_valid", 32'h1, {31'h0, acc_valid});
      chk("acc_is_reg", {31'h0, !pci}, {31'h0, acc_is_reg});
      chk("acc_write", {31'h0, wr}, {31'h0, acc_write});
      chk("acc_reg_offset", {20'h0, addr[11:0]}, {20'h0, acc_reg_offset});
      chk("parity_error", 32'h0, {31'h0, parity_error});
      chk("burst_indicator_n", {31'h0, !d[0]}, {31'h0, lb.burst_indicator_n});
      chk("acc_dma", 32'h0, {31'h0, acc_dma});
      chk("acc_single_addr", 32'h0, {31'h0, acc_single_addr});
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("done", 32'h1, {31'h0, done});
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      failures = 0;
      compares = 0;
      cycles = 0;
      {reset_n, want_master, pci_write_dir, ififo_ready, start, start_write} = 6'h00;
      {start_burst, start_pci, sel_delay} = 4'h0;
      start_addr = 32'h0;
      start_data = 32'h0;
      do_reset(1'b1, 1'b1);
      want_master = 1'b1;
      tick(10);
      chk("bus_owned", 32'h1, {31'h0, bus_owned});
      want_master = 1'b0;
      tick(10);
      for (int i = 0; i < 8; i++) begin
         access(i[0], i[1], i[1:0] + i[2], 32'hf000_0ff0 + 32'h0111 * i);
      end
      do_reset(1'b0, 1'b0);
      want_master = 1'b1;
      tick(10);
      chk("bus_request_n", 32'h1, {31'h0, lb.bus_request_n});
      chk("bus_owned", 32'h0, {31'h0, bus_owned});
      want_master = 1'b0;
      chk("dma_request_n", 32'h1, {31'h0, lb.dma_request_n});
      do_reset(1'b1, 1'b1);
      start_data = 32'hc3a5_1e69;
      start_write = 1'b1;
      sel_delay = 2'h2;
      pci_write_dir = 1'b1;
      n = 0;
      while (ififo_valid !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      tick(100);
      chk("dma_request_n", 32'h1, {31'h0, lb.dma_request_n});
      chk("acc_dma", 32'h1, {31'h0, acc_dma});
      chk("acc_single_addr", 32'h1, {31'h0, acc_single_addr});
      ififo_ready = 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
         chk("ififo_valid", 32'h1, {31'h0, ififo_valid});
         chk("ififo_data", start_data, ififo_data);
         tick(1);
      end
      test_done();
   end
endmodule
